/* File: design/arc_async_rx_confirm_and_irq.sv */
// Receive-record framer, transmit confirmation builder and host interrupt collector.
// Assumes same-clock producers for receive quadlets, confirmations and area events.
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
module arc_async_rx_confirm_and_irq #(
    parameter int AREA_BITS = 32
) (
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // Avalon-MM register slave.
    input  wire logic [5:0]                    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic      [31:0]                   avs_readdata,
    output logic                               avs_waitrequest,
    // Received packet quadlets.
    input  wire arc_pkg::arc_rx_t              rxIn,
    output logic                               rxReady,
    // Transmit results.
    input  wire arc_pkg::arc_conf_t            confIn,
    output logic                               confReady,
    // Receive queue write port.
    output arc_pkg::arc_qwr_t                  qOut,
    input  wire logic                          qReady,
    // Area events and host interrupt.
    input  wire logic [3:0][AREA_BITS-1:0]     areaEvt,
    output logic                               host_irq_n
);
    import arc_pkg::*;

    arc_state_t  state_q;
    arc_state_t  state_d;
    arc_qwr_t    qOut_q;
    arc_kind_t   kind_q;
    logic        resp_q;
    logic        err_q;
    logic [3:0]  ack_q;
    logic [3:0]  tcode_q;
    logic [2:0]  idx_q;
    logic [31:0] phyFirst_q;
    logic        confPend_q;
    logic        confResp_q;
    logic [3:0]  confCode_q;
    logic [3:0][AREA_BITS-1:0] flags_q;
    logic [3:0][AREA_BITS-1:0] enable_q;
    logic        irqN_q;
    logic        busDone_q;
    logic [31:0] rdData_q;

    // Output register and framer.
    wire outFree   = !qOut_q.valid || qReady;
    wire startRx   = rxIn.valid && rxIn.first;
    wire inIdle    = state_q == ARC_ST_IDLE;
    wire confGo    = inIdle && confPend_q && outFree;
    wire startGo   = inIdle && !confPend_q && startRx && outFree;
    wire hdrGo     = startGo && rxIn.kind != ARC_KIND_BLOCK;
    wire takeRx    = state_q == ARC_ST_BODY && rxIn.valid && outFree;
    wire statusGo  = state_q == ARC_ST_STATUS && outFree;
    wire isLock    = tcode_q == TCODE_LOCK_REQ || tcode_q == TCODE_LOCK_RESP;
    wire extZero   = kind_q == ARC_KIND_BLOCK && idx_q == IDX_EXT_TCODE && !isLock;
    wire phyCheck  = kind_q == ARC_KIND_PHY && idx_q == IDX_PHY_CHECK;
    wire phyBad    = phyCheck && rxIn.quad != ~phyFirst_q;
    wire storeRx   = takeRx && (kind_q != ARC_KIND_PHY || idx_q == 3'h0);
    wire [31:0] rxQuad = extZero ?
        {rxIn.quad[31:EXT_TC_BITS], {EXT_TC_BITS{1'b0}}} : rxIn.quad;
    wire [3:0]  statusAck = (kind_q == ARC_KIND_BLOCK) ? ack_q :
        (err_q ? ACK_DATA_ERROR : ACK_COMPLETE);
    wire        emitValid = confGo || hdrGo || storeRx || statusGo;
    wire        emitResp  = confGo ? confResp_q : (hdrGo ? rxIn.resp : resp_q);
    wire        emitLast  = confGo || statusGo;
    wire [31:0] emitData  = confGo ? {28'h000_0000, confCode_q} :
        hdrGo ? SYNTH_HEADER :
        storeRx ? rxQuad :
        {statusAck, 28'h000_0000};
    wire recDone = emitValid && emitLast;

    assign rxReady   = takeRx || (startGo && rxIn.kind == ARC_KIND_SELFID && 1'b0);
    assign confReady = !confPend_q;
    assign qOut      = qOut_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ARC_ST_IDLE:   if (startGo) state_d = ARC_ST_BODY;
            ARC_ST_BODY:   if (takeRx && rxIn.last) state_d = ARC_ST_STATUS;
            ARC_ST_STATUS: if (statusGo) state_d = ARC_ST_IDLE;
            default:       state_d = ARC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ARC_ST_IDLE;
            qOut_q  <= '0;
        end else begin
            state_q <= state_d;
            if (outFree) begin
                qOut_q <= '{valid: emitValid, resp: emitResp, last: emitLast, data: emitData};
            end
        end
    end

    // Per-record context, latched when a record opens and updated as its quadlets are taken.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            kind_q     <= ARC_KIND_BLOCK;
            resp_q     <= 1'b0;
            err_q      <= 1'b0;
            ack_q      <= 4'h0;
            tcode_q    <= 4'h0;
            idx_q      <= 3'h0;
            phyFirst_q <= 32'h0000_0000;
        end else if (startGo) begin
            kind_q  <= rxIn.kind;
            resp_q  <= rxIn.resp;
            err_q   <= 1'b0;
            idx_q   <= 3'h0;
            tcode_q <= rxIn.quad[TCODE_LSB +: 4];
        end else if (takeRx) begin
            if (idx_q != 3'h7) begin
                idx_q <= idx_q + 3'h1;
            end
            if (idx_q == 3'h0) begin
                phyFirst_q <= rxIn.quad;
            end
            err_q <= err_q || rxIn.err || phyBad;
            if (rxIn.last) begin
                ack_q <= rxIn.ack;
            end
        end
    end

    // Confirmation builder; one slot, back-pressured while occupied.
    logic [3:0] confCode;
    always_comb begin
        if (confIn.retryOut) begin
            confCode = CONF_RETRY_OUT;
        end else if (confIn.bcast) begin
            confCode = CONF_COMPLETE;
        end else if (confIn.noAck) begin
            confCode = CONF_NO_ACK;
        end else begin
            case (confIn.ack)
                ACK_COMPLETE:   confCode = CONF_COMPLETE;
                ACK_PENDING:    confCode = CONF_PENDING;
                ACK_DATA_ERROR: confCode = CONF_DATA_ERROR;
                ACK_TYPE_ERROR: confCode = CONF_TYPE_ERROR;
                default:        confCode = CONF_RETRY_OUT;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            confPend_q <= 1'b0;
            confResp_q <= 1'b0;
            confCode_q <= 4'h0;
        end else if (confIn.done && confReady) begin
            confPend_q <= 1'b1;
            confResp_q <= confIn.resp;
            confCode_q <= confCode;
        end else if (confGo) begin
            confPend_q <= 1'b0;
        end
    end

    // Register bus: one wait cycle, then the answer.
    wire busReq   = avs_read || avs_write;
    wire busTake  = busReq && busDone_q;
    wire fullWord = avs_byteenable == 4'hf;
    wire wrTake   = busTake && avs_write && fullWord;
    assign avs_waitrequest = busReq && !busDone_q;
    assign avs_readdata    = rdData_q;

    logic [3:0] summary;
    logic [3:0] flagSel;
    logic [3:0] enSel;
    logic [3:0][AREA_BITS-1:0] ownEvt;
    always_comb begin
        ownEvt = '0;
        ownEvt[AREA_ASYNC][ASY_BIT_REQ_RECORD]  = recDone && !emitResp;
        ownEvt[AREA_ASYNC][ASY_BIT_RESP_RECORD] = recDone && emitResp;
    end

    genvar a;
    generate
        for (a = 0; a < NUM_AREAS; a++) begin : gArea
            assign flagSel[a] = avs_address == OFF_LINK_PHY_EVENT_FLAGS + 6'(4 * a);
            assign enSel[a]   = avs_address == OFF_LINK_PHY_EVENT_EN + 6'(4 * a);
            assign summary[a] = |(flags_q[a] & enable_q[a]);
            wire [AREA_BITS-1:0] clr = (wrTake && flagSel[a]) ?
                avs_writedata[AREA_BITS-1:0] : '0;
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    flags_q[a]  <= AREA_BITS'(RST_FLAGS);
                    enable_q[a] <= AREA_BITS'(RST_ENABLE);
                end else begin
                    flags_q[a] <= (flags_q[a] & ~clr) | areaEvt[a] | ownEvt[a];
                    if (wrTake && enSel[a]) begin
                        enable_q[a] <= avs_writedata[AREA_BITS-1:0];
                    end
                end
            end
        end
    endgenerate

    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        if (avs_address == OFF_GLOBAL_SUMMARY_REG) begin
            rdMux = {28'h000_0000, summary};
        end
        for (int i = 0; i < NUM_AREAS; i++) begin
            if (flagSel[i]) begin
                rdMux = 32'(flags_q[i]);
            end
            if (enSel[i]) begin
                rdMux = 32'(enable_q[i]);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busDone_q <= 1'b0;
            rdData_q  <= 32'h0000_0000;
            irqN_q    <= 1'b1;
        end else begin
            busDone_q <= busReq && !busDone_q;
            if (busReq && !busDone_q) begin
                rdData_q <= rdMux;
            end
            irqN_q <= ~|summary;
        end
    end

    assign host_irq_n = irqN_q;

endmodule

/* File: design/arc_pkg.sv */
// Shared constants and carrier types for the receive-record framer and interrupt block.
// Assumes one 10 MHz clock domain and a quadlet-wide receive queue writer downstream.
package arc_pkg;

    // Register byte offsets on the host bus.
    localparam logic [5:0] OFF_GLOBAL_SUMMARY_REG   = 6'h00;
    localparam logic [5:0] OFF_LINK_PHY_EVENT_FLAGS = 6'h04;
    localparam logic [5:0] OFF_AV_TX_EVENT_FLAGS    = 6'h08;
    localparam logic [5:0] OFF_AV_RX_EVENT_FLAGS    = 6'h0c;
    localparam logic [5:0] OFF_ASYNC_EVENT_FLAGS    = 6'h10;
    localparam logic [5:0] OFF_LINK_PHY_EVENT_EN    = 6'h14;
    localparam logic [5:0] OFF_AV_TX_EVENT_EN       = 6'h18;
    localparam logic [5:0] OFF_AV_RX_EVENT_EN       = 6'h1c;
    localparam logic [5:0] OFF_ASYNC_EVENT_EN       = 6'h20;

    // Reset values.
    localparam logic [31:0] RST_FLAGS  = 32'h0000_0000;
    localparam logic [31:0] RST_ENABLE = 32'h0000_0000;

    // Area order inside the summary nibble.
    localparam int AREA_LINK_PHY = 0;
    localparam int AREA_AV_TX    = 1;
    localparam int AREA_AV_RX    = 2;
    localparam int AREA_ASYNC    = 3;
    localparam int NUM_AREAS     = 4;

    // Own events in the async area.
    localparam int ASY_BIT_REQ_RECORD  = 0;
    localparam int ASY_BIT_RESP_RECORD = 1;

    // Packet header fields.
    localparam int TCODE_LSB   = 4;
    localparam int ACK_LSB     = 28;
    localparam int EXT_TC_BITS = 16;
    localparam logic [3:0] TCODE_LOCK_REQ  = 4'h9;
    localparam logic [3:0] TCODE_LOCK_RESP = 4'hb;
    localparam logic [3:0] TCODE_SYNTH     = 4'he;
    localparam logic [31:0] SYNTH_HEADER   = 32'h0000_00e0;
    localparam logic [2:0]  IDX_EXT_TCODE  = 3'h3;
    localparam logic [2:0]  IDX_PHY_CHECK  = 3'h1;

    // Acknowledge encodings.
    localparam logic [3:0] ACK_COMPLETE   = 4'h1;
    localparam logic [3:0] ACK_PENDING    = 4'h2;
    localparam logic [3:0] ACK_DATA_ERROR = 4'hd;
    localparam logic [3:0] ACK_TYPE_ERROR = 4'he;

    // Confirmation codes.
    localparam logic [3:0] CONF_NO_ACK     = 4'h0;
    localparam logic [3:0] CONF_COMPLETE   = 4'h1;
    localparam logic [3:0] CONF_PENDING    = 4'h2;
    localparam logic [3:0] CONF_RETRY_OUT  = 4'h4;
    localparam logic [3:0] CONF_DATA_ERROR = 4'hd;
    localparam logic [3:0] CONF_TYPE_ERROR = 4'he;

    typedef enum logic [1:0] {
        ARC_KIND_BLOCK  = 2'h0,
        ARC_KIND_SELFID = 2'h1,
        ARC_KIND_PHY    = 2'h2
    } arc_kind_t;

    typedef enum logic [1:0] {
        ARC_ST_IDLE   = 2'h0,
        ARC_ST_BODY   = 2'h1,
        ARC_ST_STATUS = 2'h3
    } arc_state_t;

    typedef struct packed {
        logic        valid;
        logic        first;
        logic        last;
        logic        resp;
        logic        err;
        arc_kind_t   kind;
        logic [3:0]  ack;
        logic [31:0] quad;
    } arc_rx_t;

    typedef struct packed {
        logic       done;
        logic       resp;
        logic       bcast;
        logic       noAck;
        logic       retryOut;
        logic [3:0] ack;
    } arc_conf_t;

    typedef struct packed {
        logic        valid;
        logic        resp;
        logic        last;
        logic [31:0] data;
    } arc_qwr_t;

endpackage

/* File: sim/arc_checker.sv */
// Port-level checker for the receive framer and interrupt block.
// Assumes it is bound to the block's top module and sees only its ports.
module arc_checker #(
    parameter int AREA_BITS = 32
) (
    input wire logic                      clk,
    input wire logic                      sys_rst,
    input wire logic [5:0]                avs_address,
    input wire logic                      avs_read,
    input wire logic                      avs_write,
    input wire logic [31:0]               avs_readdata,
    input wire logic                      avs_waitrequest,
    input wire arc_pkg::arc_rx_t          rxIn,
    input wire logic                      rxReady,
    input wire arc_pkg::arc_conf_t        confIn,
    input wire logic                      confReady,
    input wire arc_pkg::arc_qwr_t         qOut,
    input wire logic                      qReady,
    input wire logic [3:0][AREA_BITS-1:0] areaEvt,
    input wire logic                      host_irq_n
);
    import arc_pkg::*;
    logic evtSeen_q;
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst) evtSeen_q <= 1'b0;
        else if (|areaEvt || (qOut.valid && qOut.last)) evtSeen_q <= 1'b1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wait_cycle_a: assert property (($rose(avs_read) || $rose(avs_write)) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("wait cycle wrong");
    q_hold_a: assert property (qOut.valid && !qReady |=> $stable(qOut))
        else $error("queue word moved");
    conf_busy_a: assert property (confIn.done && confReady |=> !confReady)
        else $error("second confirmation open");
    conf_out_a: assert property (confIn.done && confReady |-> ##[1:40]
        (qOut.valid && qOut.last && qOut.data[31:4] == 28'h0)) else $error("no confirmation");
    irq_quiet_a: assert property (!evtSeen_q |-> host_irq_n)
        else $error("interrupt without event");
    sum_ro_a: assert property (avs_read && !avs_waitrequest &&
        avs_address == OFF_GLOBAL_SUMMARY_REG |-> avs_readdata[31:4] == 28'h0)
        else $error("summary upper bits set");
    unmapped_a: assert property (avs_read && !avs_waitrequest && avs_address > 6'h20
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    self_copy_a: assert property (rxIn.valid && rxReady && rxIn.kind == ARC_KIND_SELFID
        |=> qOut.valid && qOut.data == $past(rxIn.quad)) else $error("self id word lost");
    self_bad_a: assert property (rxIn.valid && rxReady && rxIn.last && rxIn.err &&
        rxIn.kind == ARC_KIND_SELFID |-> ##[2:30]
        (qOut.valid && qOut.last && qOut.data == {ACK_DATA_ERROR, 28'h0}))
        else $error("self id error status");
    self_good_a: assert property (rxIn.valid && rxReady && rxIn.last && !rxIn.err &&
        rxIn.kind == ARC_KIND_SELFID |-> ##[2:30]
        (qOut.valid && qOut.last && qOut.data == {ACK_COMPLETE, 28'h0}))
        else $error("self id good status");
endmodule
bind arc_async_rx_confirm_and_irq arc_checker #(.AREA_BITS(AREA_BITS)) chk_u (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rxIn(rxIn), .rxReady(rxReady), .confIn(confIn), .confReady(confReady), .qOut(qOut),
    .qReady(qReady), .areaEvt(areaEvt), .host_irq_n(host_irq_n));

/* File: sim/arc_queue_sink.sv */
// Host-side reader model that logs every quadlet written to the receive queues.
// Assumes the framer's qOut handshake; stall holds qReady high one cycle in four.
module arc_queue_sink (
    // Clock and reset.
    input wire logic           clk,
    input wire logic           sys_rst,
    // Queue write port.
    input wire arc_pkg::arc_qwr_t qOut,
    input wire logic           stall,
    output logic               qReady
);
    import arc_pkg::*;
    logic [33:0] got[$];
    logic [1:0]  cnt_q;
    // A slow reader is the case that proves the framer holds its output.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q  <= '0;
            qReady <= 1'b0;
        end else begin
            cnt_q  <= cnt_q + 2'h1;
            qReady <= !stall || cnt_q == 2'h0;
            if (qOut.valid && qReady) got.push_back({qOut.resp, qOut.last, qOut.data});
        end
    end
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench: register bus, records, confirmations, interrupts.
// Assumes the queue sink model as reader and the bound port checker.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import arc_pkg::*;
    logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, qStall = 0;
    logic confReady, rxReady, qReady, host_irq_n, avs_waitrequest;
    logic [5:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, rd;
    logic [3:0] avs_byteenable = '0;
    arc_rx_t rxIn = '0;
    arc_conf_t confIn = '0;
    arc_qwr_t qOut;
    logic [3:0][31:0] areaEvt = '0;
    logic [33:0] expQ[$];
    logic [31:0] qd[8];
    logic [11:0] cf[8] = '{12'h104, 12'h401, 12'h200, 12'h011, 12'h022, 12'h0dd, 12'h0ee, 12'h044};
    int n_mismatch = 0, total_checks = 0;
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
    arc_async_rx_confirm_and_irq dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rxIn(rxIn), .rxReady(rxReady), .confIn(confIn),
        .confReady(confReady), .qOut(qOut), .qReady(qReady), .areaEvt(areaEvt),
        .host_irq_n(host_irq_n));
    arc_queue_sink host_u (.clk(clk), .sys_rst(sys_rst), .qOut(qOut), .stall(qStall),
        .qReady(qReady));
    initial forever #50 clk = ~clk;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Handshakes are sampled at the falling edge so the taking edge is never raced.
    task automatic hold(input int w);
        int n = 0;
        do begin @(negedge clk); n++; end
        while (!(w == 0 ? avs_waitrequest === 1'b0 : w == 1 ? rxReady === 1'b1 :
            confReady === 1'b1) && n < 200);
        if (n >= 200) begin n_mismatch++; end_of_test(); end
        @(posedge clk);
    endtask
    // The bus master samples waitrequest at the rising edge that takes the request.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       input logic [3:0] be = 4'hf);
        int n = 0;
        @(posedge clk);
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= {!w, w, a, d, be};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 200);
        rd = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
        if (n >= 200) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    task automatic rec(input arc_kind_t k, input logic r, e, input logic [3:0] a, int n);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxIn <= '{1'b1, i == 0, i == n - 1, r, e, k, a, qd[i]};
            hold(1);
        end
        rxIn <= '0;
    endtask
    function automatic void ex(logic r, l, logic [31:0] d);
        expQ.push_back({r, l, d});
    endfunction
    task automatic drain();
        for (int n = 0; n < 300 && host_u.got.size() < expQ.size(); n++) @(posedge clk);
        repeat (8) @(posedge clk);
        `CK(host_u.got.size(), expQ.size())
        foreach (expQ[i]) `CK(host_u.got[i], expQ[i])
        host_u.got.delete();
        expQ.delete();
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            bus(0, 6'(4 * i), '0);
            `CK(rd, 32'h0)
        end
        bus(1, OFF_AV_TX_EVENT_EN, 32'hffff_ffff, 4'h3);
        bus(0, OFF_AV_TX_EVENT_EN, '0);
        `CK(rd, 32'h0)
        for (int i = 0; i < 4; i++) begin
            bus(1, OFF_LINK_PHY_EVENT_EN + 6'(4 * i), 32'h0000_0030);
            areaEvt[i] <= 32'h0000_0050;
            @(posedge clk) areaEvt[i] <= '0;
            bus(0, OFF_GLOBAL_SUMMARY_REG, '0);
            `CK(rd, 32'(1 << i))
            `CK(host_irq_n, 1'b0)
            bus(0, OFF_LINK_PHY_EVENT_FLAGS + 6'(4 * i), '0);
            `CK(rd, 32'h0000_0050)
            bus(1, OFF_LINK_PHY_EVENT_FLAGS + 6'(4 * i), 32'hffff_ffcf);
            `CK(host_irq_n, 1'b0)
            bus(1, OFF_LINK_PHY_EVENT_FLAGS + 6'(4 * i), 32'h0000_0010);
            repeat (2) @(negedge clk);
            `CK(host_irq_n, 1'b1)
            bus(0, OFF_GLOBAL_SUMMARY_REG, '0);
            `CK(rd, 32'h0)
        end
        $display("interrupt test done");
        qStall <= 1'b1;
        qd = '{32'h1234_0090, 32'hffc0_0001, 32'h0000_1000, 32'h0008_0003, 32'hdead_beef,
               32'h0102_0304, 32'h0, 32'h0};
        rec(ARC_KIND_BLOCK, 0, 0, ACK_PENDING, 6);
        for (int i = 0; i < 6; i++) ex(0, 0, qd[i]);
        ex(0, 1, {ACK_PENDING, 28'h0});
        qd[0] = 32'h1234_0010;
        rec(ARC_KIND_BLOCK, 1, 0, ACK_COMPLETE, 4);
        for (int i = 0; i < 3; i++) ex(1, 0, qd[i]);
        ex(1, 0, 32'h0008_0000);
        ex(1, 1, {ACK_COMPLETE, 28'h0});
        drain();
        $display("block test done");
        qd[0] = 32'h8040_0c00;
        for (int c = 0; c < 4; c++) begin
            qd[1] = c == 3 ? qd[0] : ~qd[0];
            rec(c < 2 ? ARC_KIND_SELFID : ARC_KIND_PHY, c > 1, c == 1, 4'h0, 2);
            ex(c > 1, 0, SYNTH_HEADER);
            ex(c > 1, 0, qd[0]);
            if (c < 2) ex(0, 0, qd[1]);
            ex(c > 1, 1, {c[0] ? ACK_DATA_ERROR : ACK_COMPLETE, 28'h0});
        end
        drain();
        $display("self id and phy test done");
        for (int j = 0; j < 8; j++) begin
            confIn <= '{1'b1, j[0], cf[j][10], cf[j][9], cf[j][8], cf[j][7:4]};
            hold(2);
            ex(j[0], 1, {28'h0, cf[j][3:0]});
        end
        confIn <= '0;
        drain();
        $display("confirmation test done");
        end_of_test();
    end
endmodule
